// File: core/mac_cfg.svh
// widths, field positions and encodings for the multiply-accumulate coprocessor
`ifndef MAC_CFG_SVH
`define MAC_CFG_SVH
`define MAC_ACC_W 40
`define MAC_WORD_W 32
`define MAC_HALF_W 16
`define MAC_ACC_HI_W 8
`define MAC_PROD_W 64
`define MAC_SEL_W 2
`define MAC_SEL_LL 2'h0
`define MAC_SEL_LH 2'h1
`define MAC_SEL_HL 2'h2
`define MAC_SEL_HH 2'h3
`define MAC_WORD_LO 1'h0
`define MAC_WORD_HI 1'h1
`define MAC_ACC_RST 40'h00_0000_0000
`endif

// File: core/mac_coproc.sv
// mac coprocessor end: 40-bit accumulator and multiply-accumulate datapath
`timescale 1ns/1ps
`default_nettype none
`include "mac_cfg.svh"

// How it works
// - one 40-bit accumulator, three signed multiply forms
// - accumulator-to-pair move returns it in two registers
// - pair-to-accumulator move loads from two registers
// - save or restore takes two word transfers
// - halfword mac picks halves per variant
// - halfword product sign-extended, added to accumulator
// - dual mac multiplies high pair, low pair
// - both dual products added in one operation
// - word mac adds low 40 product bits
// - 16x32 word mac finishes in one cycle
// - transfers are 32-bit, at core clock
// - tight mode: core stalls until done
// - parallel mode: core runs on, multi-step allowed
module mac_coproc
  import mac_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link to the core
  mac_if.coproc lnk
);

  typedef enum logic {
    MAC_ST_IDLE,
    MAC_ST_WORD_HI
  } mac_st_t;

  // pick one signed halfword of a register
  function automatic logic signed [`MAC_HALF_W-1:0] half_pick(
    input logic [`MAC_WORD_W-1:0] w,
    input logic hi
  );
    half_pick = hi ? w[31:16] : w[15:0];
  endfunction

  // sign-extend a 32-bit product to accumulator width
  function automatic logic [`MAC_ACC_W-1:0] sext32(
    input logic [`MAC_WORD_W-1:0] p
  );
    sext32 = {{(`MAC_ACC_W-`MAC_WORD_W){p[31]}}, p};
  endfunction

  mac_st_t st_q; // micro-step state
  mac_st_t st_d;
  logic [`MAC_ACC_W-1:0] acc_q; // the accumulator
  logic [`MAC_ACC_W-1:0] acc_d;
  logic [`MAC_WORD_W-1:0] wa_q; // word mac multiplier held for step two
  logic [`MAC_WORD_W-1:0] wb_q; // word mac multiplicand held for step two
  logic done_q; // completion pulse
  logic done_d;
  logic [`MAC_WORD_W-1:0] res_lo_q; // answer words
  logic [`MAC_WORD_W-1:0] res_hi_q;
  logic [`MAC_WORD_W-1:0] res_lo_d;
  logic [`MAC_WORD_W-1:0] res_hi_d;

  // command accepted this cycle
  wire logic take = lnk.cmd_valid && lnk.cmd_ready;

  // halfword mac: sel[1] picks multiplier half, sel[0] multiplicand half
  wire logic signed [15:0] hw_a = half_pick(lnk.cmd_a, lnk.cmd_sel[1]);
  wire logic signed [15:0] hw_b = half_pick(lnk.cmd_b, lnk.cmd_sel[0]);
  wire logic signed [31:0] hw_prod = hw_a * hw_b;
  wire logic [`MAC_ACC_W-1:0] hw_ext = sext32(hw_prod);

  // dual mac: lane 0 low halves, lane 1 high halves
  logic [`MAC_ACC_W-1:0] dual_ext [2];
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lane
      // lane index as a plain one-bit select, high lane takes upper halves
      wire logic lane_hi = (g == 1);
      wire logic signed [15:0] la = half_pick(lnk.cmd_a, lane_hi);
      wire logic signed [15:0] lb = half_pick(lnk.cmd_b, lane_hi);
      wire logic signed [31:0] lp = la * lb;
      assign dual_ext[g] = sext32(lp);
    end
  endgenerate
  wire logic [`MAC_ACC_W-1:0] dual_sum = dual_ext[0] + dual_ext[1];

  // word mac: short multiplier fits 16 signed bits, one cycle
  wire logic a_short = (lnk.cmd_a[31:15] == {17{lnk.cmd_a[15]}});
  wire logic signed [47:0] w16_prod = $signed(lnk.cmd_a[15:0]) * $signed(lnk.cmd_b);
  wire logic [`MAC_ACC_W-1:0] w16_ext = w16_prod[`MAC_ACC_W-1:0];
  // long multiplier, step one: unsigned low half times signed multiplicand
  wire logic signed [48:0] wlo_prod = $signed({1'b0, lnk.cmd_a[15:0]}) * $signed(lnk.cmd_b);
  wire logic [`MAC_ACC_W-1:0] wlo_ext = wlo_prod[`MAC_ACC_W-1:0];
  // long multiplier, step two: signed high half times multiplicand, shifted
  wire logic signed [47:0] whi_prod = $signed(wa_q[31:16]) * $signed(wb_q);
  wire logic [`MAC_ACC_W-1:0] whi_ext = {whi_prod[`MAC_ACC_W-17:0], 16'h0000};

  // accumulator high byte widened to a register
  wire logic [`MAC_WORD_W-1:0] acc_hi_word = {{24{acc_q[39]}}, acc_q[39:32]};

  // ready only when no micro-step is pending
  assign lnk.cmd_ready = (st_q == MAC_ST_IDLE);
  assign lnk.done = done_q;
  assign lnk.res_lo = res_lo_q;
  assign lnk.res_hi = res_hi_q;

  // command decode and accumulator update
  always_comb begin
    st_d = st_q;
    acc_d = acc_q;
    done_d = 1'b0;
    res_lo_d = res_lo_q;
    res_hi_d = res_hi_q;
    case (st_q)
      MAC_ST_IDLE: begin
        if (take) begin
          done_d = 1'b1;
          case (lnk.cmd_op)
            // sums wrap at 40 bits
            MAC_OP_HALFWORD_MAC: begin
              acc_d = acc_q + hw_ext;
            end
            MAC_OP_DUAL_HALFWORD_MAC: begin
              acc_d = acc_q + dual_sum;
            end
            MAC_OP_WORD_MAC: begin
              if (a_short) begin
                acc_d = acc_q + w16_ext;
              end else begin
                // two micro-steps; completion held back
                acc_d = acc_q + wlo_ext;
                done_d = 1'b0;
                st_d = MAC_ST_WORD_HI;
              end
            end
            MAC_OP_ACC_TO_REG_PAIR_MOVE: begin
              res_lo_d = acc_q[31:0];
              res_hi_d = acc_hi_word;
            end
            MAC_OP_REG_PAIR_TO_ACC_MOVE: begin
              acc_d = {lnk.cmd_b[7:0], lnk.cmd_a};
            end
            MAC_OP_COPROC_STORE: begin
              // word index picks low word or sign-extended top byte
              res_lo_d = lnk.cmd_sel[0] ? acc_hi_word : acc_q[31:0];
            end
            MAC_OP_COPROC_LOAD: begin
              if (lnk.cmd_sel[0] == `MAC_WORD_HI) begin
                acc_d = {lnk.cmd_a[7:0], acc_q[31:0]};
              end else begin
                acc_d = {acc_q[39:32], lnk.cmd_a};
              end
            end
            default: begin
              done_d = 1'b0;
            end
          endcase
        end
      end
      MAC_ST_WORD_HI: begin
        // second step finishes the long word mac
        acc_d = acc_q + whi_ext;
        done_d = 1'b1;
        st_d = MAC_ST_IDLE;
      end
      default: begin
        st_d = MAC_ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= MAC_ST_IDLE;
      acc_q <= `MAC_ACC_RST;
      done_q <= 1'b0;
      res_lo_q <= 32'h0000_0000;
      res_hi_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      acc_q <= acc_d;
      done_q <= done_d;
      res_lo_q <= res_lo_d;
      res_hi_q <= res_hi_d;
    end
  end

  // operands held for the second micro-step
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wa_q <= 32'h0000_0000;
      wb_q <= 32'h0000_0000;
    end else if (take) begin
      wa_q <= lnk.cmd_a;
      wb_q <= lnk.cmd_b;
    end
  end

endmodule
`default_nettype wire

// File: core/mac_core_end.sv
// core end: issues coprocessor commands, tight or parallel
`timescale 1ns/1ps
`default_nettype none
`include "mac_cfg.svh"
module mac_core_end
  import mac_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // user request
  input wire logic req_valid,
  input wire logic req_tight,
  input wire mac_op_t req_op,
  input wire logic [1:0] req_sel,
  input wire logic [31:0] req_a,
  input wire logic [31:0] req_b,
  output logic req_ready,
  // user answer
  output logic rsp_valid,
  output logic [31:0] rsp_lo,
  output logic [31:0] rsp_hi,
  // link to the coprocessor
  mac_if.core lnk
);

  typedef enum logic [1:0] {
    MAC_CE_IDLE,
    MAC_CE_ISSUE,
    MAC_CE_WAIT
  } mac_ce_st_t;

  mac_ce_st_t st_q; // issue state
  logic tight_q; // held mode of the command in flight
  mac_op_t op_q; // held command
  logic [1:0] sel_q;
  logic [31:0] a_q;
  logic [31:0] b_q;
  logic rsp_valid_q; // answer pulse
  logic [31:0] rsp_lo_q;
  logic [31:0] rsp_hi_q;

  // stalls the user while issuing, and in tight mode until done
  assign req_ready = (st_q == MAC_CE_IDLE);
  assign lnk.cmd_valid = (st_q == MAC_CE_ISSUE);
  assign lnk.cmd_op = op_q;
  assign lnk.cmd_sel = sel_q;
  assign lnk.cmd_a = a_q;
  assign lnk.cmd_b = b_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_lo = rsp_lo_q;
  assign rsp_hi = rsp_hi_q;

  // issue sequence
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= MAC_CE_IDLE;
      tight_q <= 1'b0;
      op_q <= MAC_OP_HALFWORD_MAC;
      sel_q <= 2'h0;
      a_q <= 32'h0000_0000;
      b_q <= 32'h0000_0000;
    end else begin
      case (st_q)
        MAC_CE_IDLE: begin
          if (req_valid) begin
            st_q <= MAC_CE_ISSUE;
            tight_q <= req_tight;
            op_q <= req_op;
            sel_q <= req_sel;
            a_q <= req_a;
            b_q <= req_b;
          end
        end
        MAC_CE_ISSUE: begin
          // parallel mode frees the user once taken
          if (lnk.cmd_ready) begin
            st_q <= tight_q ? MAC_CE_WAIT : MAC_CE_IDLE;
          end
        end
        MAC_CE_WAIT: begin
          if (lnk.done) begin
            st_q <= MAC_CE_IDLE;
          end
        end
        default: begin
          st_q <= MAC_CE_IDLE;
        end
      endcase
    end
  end

  // capture answers on every completion
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_lo_q <= 32'h0000_0000;
      rsp_hi_q <= 32'h0000_0000;
    end else begin
      rsp_valid_q <= lnk.done;
      if (lnk.done) begin
        rsp_lo_q <= lnk.res_lo;
        rsp_hi_q <= lnk.res_hi;
      end
    end
  end

endmodule
`default_nettype wire

// File: core/mac_if.sv
// command and answer link between core and mac coprocessor
`timescale 1ns/1ps
`default_nettype none
interface mac_if;
  import mac_pkg::*;
  logic cmd_valid; // core offers a command
  logic cmd_ready; // coprocessor can take one
  mac_op_t cmd_op; // command
  logic [1:0] cmd_sel; // halfword select, or word index
  logic [31:0] cmd_a; // multiplier / low register / load word
  logic [31:0] cmd_b; // multiplicand / high register
  logic done; // one-cycle completion pulse
  logic [31:0] res_lo; // low register / store word
  logic [31:0] res_hi; // high register
  modport coproc (input cmd_valid, cmd_op, cmd_sel, cmd_a, cmd_b,
                  output cmd_ready, done, res_lo, res_hi);
  modport core (output cmd_valid, cmd_op, cmd_sel, cmd_a, cmd_b,
                input cmd_ready, done, res_lo, res_hi);
endinterface
`default_nettype wire

// File: core/mac_pkg.sv
// types shared by both ends of the coprocessor link
package mac_pkg;
  // commands the core issues
  typedef enum logic [2:0] {
    MAC_OP_HALFWORD_MAC,
    MAC_OP_DUAL_HALFWORD_MAC,
    MAC_OP_WORD_MAC,
    MAC_OP_ACC_TO_REG_PAIR_MOVE,
    MAC_OP_REG_PAIR_TO_ACC_MOVE,
    MAC_OP_COPROC_STORE,
    MAC_OP_COPROC_LOAD
  } mac_op_t;
endpackage

// File: tb/mac_coproc_tb.sv
// self-checking bench: both link ends joined, reference accumulator
`timescale 1ns/1ps
`default_nettype none
module mac_coproc_tb;
  import mac_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_tight = 1'b1;
  mac_op_t req_op = MAC_OP_HALFWORD_MAC;
  logic [1:0] req_sel = 2'h0;
  logic [31:0] req_a = 32'h0;
  logic [31:0] req_b = 32'h0;
  logic req_ready;
  logic rsp_valid;
  logic [31:0] rsp_lo;
  logic [31:0] rsp_hi;
  logic [39:0] acc = 40'h0; // reference accumulator
  logic [31:0] exp_hi = 32'h0; // last pair-read high word
  logic [64:0] notes[$]; // check flag, high, low
  logic [64:0] n;
  int bad_count = 0;
  int tests_run = 0;
  int seed = 19304;
  always #10 mclk = ~mclk;
  mac_if lnk();
  mac_coproc mac_coproc_inst (.mclk(mclk), .rst(rst), .lnk(lnk));
  mac_core_end mac_core_end_inst (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_tight(req_tight),
    .req_op(req_op), .req_sel(req_sel), .req_a(req_a), .req_b(req_b), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_lo(rsp_lo), .rsp_hi(rsp_hi), .lnk(lnk));
  mac_link_properties mac_link_properties_inst (.mclk(mclk), .rst(rst), .cmd_valid(lnk.cmd_valid),
    .cmd_ready(lnk.cmd_ready), .cmd_op(lnk.cmd_op), .cmd_sel(lnk.cmd_sel), .cmd_a(lnk.cmd_a),
    .done(lnk.done), .res_lo(lnk.res_lo), .res_hi(lnk.res_hi));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // drive one request, update the model, note the expected answer
  task automatic issue(input mac_op_t op, input logic [1:0] sel, input logic [31:0] a, input logic [31:0] b,
                       input logic tight);
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [31:0] p;
    logic signed [31:0] q;
    logic signed [63:0] w;
    logic chk;
    logic [31:0] lo;
    @(negedge mclk);
    req_valid = 1'b1;
    req_op = op;
    req_sel = sel;
    req_a = a;
    req_b = b;
    req_tight = tight;
    while (req_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
    chk = 1'b0;
    lo = 32'h0;
    x = sel[1] ? a[31:16] : a[15:0];
    y = sel[0] ? b[31:16] : b[15:0];
    p = x * y;
    case (op)
      MAC_OP_HALFWORD_MAC: acc = acc + {{8{p[31]}}, p};
      MAC_OP_DUAL_HALFWORD_MAC: begin
        p = $signed(a[31:16]) * $signed(b[31:16]);
        q = $signed(a[15:0]) * $signed(b[15:0]);
        acc = acc + {{8{p[31]}}, p} + {{8{q[31]}}, q};
      end
      MAC_OP_WORD_MAC: begin
        w = $signed(a) * $signed(b);
        acc = acc + w[39:0];
      end
      MAC_OP_ACC_TO_REG_PAIR_MOVE: begin
        chk = 1'b1;
        lo = acc[31:0];
        exp_hi = {{24{acc[39]}}, acc[39:32]};
      end
      MAC_OP_REG_PAIR_TO_ACC_MOVE: acc = {b[7:0], a};
      MAC_OP_COPROC_STORE: begin
        chk = 1'b1;
        lo = sel[0] ? {{24{acc[39]}}, acc[39:32]} : acc[31:0];
      end
      default: if (sel[0]) acc[39:32] = a[7:0]; else acc[31:0] = a;
    endcase
    notes.push_back({chk, exp_hi, lo});
    // tight mode keeps the user stalled, parallel frees it once issued
    @(negedge mclk);
    check({31'h0, req_ready}, {31'h0, ~tight});
  endtask
  // result watcher: oldest note against each answer
  always @(negedge mclk) begin
    if (rsp_valid === 1'b1) begin
      // an answer with no note behind it must count as a mismatch
      n = notes.size() > 0 ? notes.pop_front() : {1'b1, ~rsp_hi, ~rsp_lo};
      if (n[64]) begin
        check(rsp_lo, n[31:0]);
        check(rsp_hi, n[63:32]);
      end
    end
  end
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) issue(MAC_OP_HALFWORD_MAC, 2'(i), $random(seed), $random(seed), 1'b1);
    issue(MAC_OP_ACC_TO_REG_PAIR_MOVE, 2'h0, 32'h0, 32'h0, 1'b1);
    $display("test 1 halfword variants done");
    issue(MAC_OP_DUAL_HALFWORD_MAC, 2'h0, $random(seed), $random(seed), 1'b1);
    issue(MAC_OP_WORD_MAC, 2'h0, 32'hFFFF_8000, $random(seed), 1'b1);
    issue(MAC_OP_WORD_MAC, 2'h0, 32'h8000_0000, 32'h8000_0001, 1'b1);
    issue(MAC_OP_ACC_TO_REG_PAIR_MOVE, 2'h0, 32'h0, 32'h0, 1'b1);
    $display("test 2 dual and word done");
    issue(MAC_OP_REG_PAIR_TO_ACC_MOVE, 2'h0, 32'hFFFF_FFFF, 32'h0000_00FF, 1'b1);
    issue(MAC_OP_HALFWORD_MAC, 2'h0, 32'h0000_7FFF, 32'h0000_7FFF, 1'b1);
    issue(MAC_OP_ACC_TO_REG_PAIR_MOVE, 2'h0, 32'h0, 32'h0, 1'b1);
    issue(MAC_OP_REG_PAIR_TO_ACC_MOVE, 2'h0, 32'hFFFF_FFFF, 32'h0000_007F, 1'b1);
    issue(MAC_OP_HALFWORD_MAC, 2'h0, 32'h0000_7FFF, 32'h0000_7FFF, 1'b1);
    issue(MAC_OP_ACC_TO_REG_PAIR_MOVE, 2'h0, 32'h0, 32'h0, 1'b1);
    $display("test 3 wrap done");
    issue(MAC_OP_COPROC_STORE, 2'h0, 32'h0, 32'h0, 1'b1);
    issue(MAC_OP_COPROC_STORE, 2'h1, 32'h0, 32'h0, 1'b1);
    issue(MAC_OP_COPROC_LOAD, 2'h1, 32'h0000_0080, 32'h0, 1'b1);
    issue(MAC_OP_COPROC_LOAD, 2'h0, $random(seed), 32'h0, 1'b1);
    issue(MAC_OP_ACC_TO_REG_PAIR_MOVE, 2'h0, 32'h0, 32'h0, 1'b1);
    $display("test 4 save and restore done");
    for (int i = 0; i < 16; i++) begin
      issue(mac_op_t'(3'($unsigned($random(seed)) % 7)), 2'($random(seed)), $random(seed), $random(seed), 1'b0);
    end
    issue(MAC_OP_ACC_TO_REG_PAIR_MOVE, 2'h0, 32'h0, 32'h0, 1'b1);
    repeat (10) @(negedge mclk);
    check(32'(notes.size()), 32'h0);
    $display("test 5 parallel random done");
    print_verdict();
  end
endmodule
`default_nettype wire

// File: tb/mac_link_properties.sv
// concurrent checks on the core-to-coprocessor link
`timescale 1ns/1ps
`default_nettype none
module mac_link_properties
  import mac_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link signals
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire mac_op_t cmd_op,
  input wire logic [1:0] cmd_sel,
  input wire logic [31:0] cmd_a,
  input wire logic done,
  input wire logic [31:0] res_lo,
  input wire logic [31:0] res_hi
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire tk = cmd_valid && cmd_ready; // command taken
  wire sh = &cmd_a[31:15] || ~|cmd_a[31:15]; // multiplier fits 16 bits
  wire hw = tk && (cmd_op == MAC_OP_HALFWORD_MAC || cmd_op == MAC_OP_DUAL_HALFWORD_MAC); // halfword forms
  wire wd = tk && cmd_op == MAC_OP_WORD_MAC; // word mac taken
  wire mv = tk && cmd_op == MAC_OP_ACC_TO_REG_PAIR_MOVE; // pair read taken
  wire st = tk && cmd_op == MAC_OP_COPROC_STORE; // store word taken
  wire xf = tk && (cmd_op == MAC_OP_REG_PAIR_TO_ACC_MOVE || cmd_op == MAC_OP_COPROC_LOAD); // loads
  hw_done_a: assert property (hw |=> done)
    else $error("halfword mac without completion");
  move_done_a: assert property (mv || st || xf |=> done)
    else $error("transfer without completion");
  short_word_a: assert property (wd && sh |=> done && cmd_ready)
    else $error("short word mac not single cycle");
  long_word_a: assert property (wd && !sh |=> !cmd_ready ##1 (done && cmd_ready))
    else $error("long word mac steps wrong");
  done_cause_a: assert property (done |-> $past(tk) || $past(wd && !sh, 2))
    else $error("completion without command");
  pair_hi_sext_a: assert property (mv |=> res_hi == {{24{res_hi[7]}}, res_hi[7:0]})
    else $error("pair high word not sign extended");
  store_top_a: assert property (st && cmd_sel[0] |=> res_lo == {{24{res_lo[7]}}, res_lo[7:0]})
    else $error("stored top word not sign extended");
  hi_hold_a: assert property (!mv |=> $stable(res_hi))
    else $error("high word changed without pair read");
  cover property (wd && !sh);
  cover property (st && cmd_sel[0]);
  cover property (mv);
endmodule
`default_nettype wire
